//--- logic/hbi_pkg.sv
// shared constants and carrier types of the 8-bit host bus port
package hbi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // access state, one-hot
  typedef enum logic [2:0] {
    HBI_IDLE  = 3'b001,
    HBI_READ  = 3'b010,
    HBI_WRITE = 3'b100
  } hbi_state_t;

  // host pins after sampling
  typedef struct packed {
    logic              core_sel_n;
    logic              hdlc_sel_n;
    logic              wr_n;       // write strobe, or direction in strobe mode
    logic              rd_n;       // read strobe, or data_strobe
    logic              ale;
    logic              ext_rst;
    logic              strobe_dir;  // 1: strobe-plus-direction style
    logic [DATA_W-1:0] ad;
    logic [ADDR_W-1:0] addr;
  } hbi_pins_t;

  localparam hbi_pins_t PINS_RST = '{core_sel_n: 1'b1, hdlc_sel_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                                     ale: 1'b0, ext_rst: 1'b0, strobe_dir: 1'b0,
                                     ad: DATA_RST, addr: ADDR_RST};

  // request toward the register space
  typedef struct packed {
    logic              rd_stb;
    logic              wr_stb;
    logic              core_sel;
    logic              hdlc_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbi_req_t;

  localparam hbi_req_t REQ_RST = '{rd_stb: 1'b0, wr_stb: 1'b0, core_sel: 1'b0, hdlc_sel: 1'b0,
                                   addr: ADDR_RST, wdata: DATA_RST};
endpackage

//--- logic/hbi_host_port.sv
// host bus port: pin sampling, bus mode choice, address latch, access sequencing
//
// Overview of operation
// - A low core select opens every register except the HDLC controller registers for reads and writes.
// - A low HDLC select opens the HDLC controller registers for reads and writes.
// - In separate-strobe style a low write strobe is taken as a write access.
// - In separate-strobe style a low read strobe is a read and register data is returned while it is low.
// - In strobe-plus-direction style the direction line high means read and low means write.
// - In strobe-plus-direction style the rising edge of the data strobe ends the access.
// - Multiplexed mode carries address then data on the shared pins; demultiplexed mode carries only data there.
// - The address latch is transparent while the latch strobe is high and holds on its falling edge.
// - The latch strobe is looked at on the first access after reset to pick multiplexed or demultiplexed mode.
// - The data pins are driven only while read data is returned and are released otherwise.
// - The data path is eight bits, with a separate address bus in demultiplexed mode.
// - The active-low open-drain interrupt line is pulled low while an interrupt is pending.
// - A high external reset forces the reset state and forgets the chosen bus mode.
`timescale 1ns/1ns
`default_nettype none
module hbi_host_port
  import hbi_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  // host control pins
  input  wire logic                      core_select_n_i,
  input  wire logic                      hdlc_select_n_i,
  input  wire logic                      wr_n_i,
  input  wire logic                      data_strobe_i,
  input  wire logic                      ale_i,
  input  wire logic                      external_reset_in_i,
  input  wire logic                      strobe_dir_mode_i,
  // host address and shared address/data pins
  input  wire logic [hbi_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [hbi_pkg::DATA_W-1:0] shared_ad_i,
  output logic      [hbi_pkg::DATA_W-1:0] shared_ad_o,
  output logic                           shared_ad_oe_o,
  // interrupt pin, open drain
  output logic                           irq_n_o,
  output logic                           irq_n_oe_o,
  // register space side
  output hbi_pkg::hbi_req_t              req_o,
  input  wire logic [hbi_pkg::DATA_W-1:0] rd_data_i,
  input  wire logic                      irq_pending_i,
  // status
  output logic                           mode_known_o,
  output logic                           mux_mode_o
);
  import hbi_pkg::*;

  typedef struct packed {
    hbi_pins_t         s1;         // first sampler stage, read only by s2
    hbi_pins_t         s2;
    hbi_state_t        st;
    logic              mode_known;
    logic              mux_mode;
    logic              ale_seen;
    logic [ADDR_W-1:0] addr_latch;
    logic              is_core;
    logic              is_hdlc;
    logic [ADDR_W-1:0] acc_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic              irq_oe;
    hbi_req_t          req;
  } hbi_regs_t;

  localparam hbi_regs_t REGS_RST = '{s1: PINS_RST, s2: PINS_RST, st: HBI_IDLE, mode_known: 1'b0,
                                     mux_mode: 1'b0, ale_seen: 1'b0, addr_latch: ADDR_RST,
                                     is_core: 1'b0, is_hdlc: 1'b0, acc_addr: ADDR_RST,
                                     wdata: DATA_RST, dout: DATA_RST, dout_oe: 1'b0,
                                     irq_oe: 1'b0, req: REQ_RST};

  // strobe decode by bus style; used for start and end of an access
  function automatic logic strobe_on(input hbi_pins_t p);
    strobe_on = p.strobe_dir ? !p.rd_n : (!p.rd_n || !p.wr_n);
  endfunction

  function automatic logic is_write(input hbi_pins_t p);
    is_write = !p.wr_n; // low write strobe, or direction low
  endfunction

  hbi_regs_t r;
  hbi_regs_t next_r;
  hbi_pins_t pin_now;
  logic      selected;
  logic      cur_mux;

  always_comb begin
    pin_now = '{core_sel_n: core_select_n_i, hdlc_sel_n: hdlc_select_n_i, wr_n: wr_n_i,
                rd_n: data_strobe_i, ale: ale_i, ext_rst: external_reset_in_i,
                strobe_dir: strobe_dir_mode_i, ad: shared_ad_i, addr: addr_i};
  end

  // next state; all pins are read through the second sampler stage only
  always_comb begin
    next_r = r;
    next_r.s1 = pin_now;
    next_r.s2 = r.s1;
    next_r.req.rd_stb = 1'b0;
    next_r.req.wr_stb = 1'b0;
    selected = !r.s2.core_sel_n || !r.s2.hdlc_sel_n;
    cur_mux  = r.mode_known ? r.mux_mode : r.ale_seen;
    // transparent while ale high, holds after it falls
    if (r.s2.ale) begin
      next_r.addr_latch = r.s2.ad;
      next_r.ale_seen   = 1'b1;
    end
    next_r.irq_oe = irq_pending_i;
    unique case (r.st)
      HBI_IDLE: begin
        if (selected && strobe_on(r.s2) && !r.s2.ale) begin
          if (!r.mode_known) begin
            next_r.mode_known = 1'b1;
            next_r.mux_mode   = r.ale_seen;
          end
          next_r.is_core  = !r.s2.core_sel_n;
          next_r.is_hdlc  = !r.s2.hdlc_sel_n;
          next_r.acc_addr = cur_mux ? r.addr_latch : r.s2.addr;
          if (is_write(r.s2)) begin
            next_r.st    = HBI_WRITE;
            next_r.wdata = r.s2.ad;
          end else begin
            next_r.st         = HBI_READ;
            next_r.req.rd_stb = 1'b1;
          end
        end
      end
      HBI_READ: begin
        next_r.dout    = rd_data_i;
        next_r.dout_oe = 1'b1;
        if (!selected || !strobe_on(r.s2)) begin
          next_r.st      = HBI_IDLE;
          next_r.dout_oe = 1'b0;
        end
      end
      HBI_WRITE: begin
        // data taken while strobe still low; late-valid host data wins
        if (selected && strobe_on(r.s2)) begin
          next_r.wdata = r.s2.ad;
        end else begin
          next_r.st         = HBI_IDLE;
          next_r.req.wr_stb = 1'b1;
        end
      end
    endcase
    next_r.req.core_sel = next_r.is_core;
    next_r.req.hdlc_sel = next_r.is_hdlc;
    next_r.req.addr     = next_r.acc_addr;
    next_r.req.wdata    = next_r.wdata;
    // external reset drops everything but the samplers, mode included
    if (r.s2.ext_rst) begin
      next_r    = REGS_RST;
      next_r.s1 = pin_now;
      next_r.s2 = r.s1;
    end
  end

  // single register for all state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // outputs, all from flops except irq_n_o, tied low
  assign shared_ad_o    = r.dout;
  assign shared_ad_oe_o = r.dout_oe;
  assign irq_n_o        = 1'b0;      // open drain: only ever pulls low
  assign irq_n_oe_o     = r.irq_oe;
  assign req_o          = r.req;
  assign mode_known_o   = r.mode_known;
  assign mux_mode_o     = r.mux_mode;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence seq_idle_start;
    r.st == HBI_IDLE && !r.s2.ext_rst && (!r.s2.core_sel_n || !r.s2.hdlc_sel_n) &&
      strobe_on(r.s2) && !r.s2.ale;
  endsequence

  sequence seq_write_release;
    r.st == HBI_WRITE && !r.s2.ext_rst && !(selected && strobe_on(r.s2));
  endsequence

  oe_only_read_a: assert property (shared_ad_oe_o |-> $past(r.st) == HBI_READ)
    else $error("data pins driven outside a read");

  mode_fixed_a: assert property (mode_known_o && !r.s2.ext_rst |=> $stable(mux_mode_o) && mode_known_o)
    else $error("bus mode changed without reset");

  ext_reset_a: assert property (r.s2.ext_rst |=> !mode_known_o && r.st == HBI_IDLE && !shared_ad_oe_o)
    else $error("external reset did not clear state");

  strobe_end_a: assert property (seq_write_release |=> req_o.wr_stb ##1 !req_o.wr_stb)
    else $error("write not completed on strobe release");

  read_drive_a: assert property (seq_idle_start ##0 r.s2.wr_n |=> req_o.rd_stb ##1 shared_ad_oe_o)
    else $error("read did not drive data");

  write_take_a: assert property (seq_idle_start ##0 !r.s2.strobe_dir && !r.s2.wr_n |=> r.st == HBI_WRITE)
    else $error("low write strobe not taken as write");

  dir_read_a: assert property (seq_idle_start ##0 r.s2.strobe_dir && r.s2.wr_n |=> r.st == HBI_READ)
    else $error("direction high not taken as read");

  latch_hold_a: assert property (!r.s2.ale && !r.s2.ext_rst |=> $stable(r.addr_latch))
    else $error("address latch moved while latch strobe low");

  latch_pass_a: assert property (r.s2.ale && !r.s2.ext_rst |=> r.addr_latch == $past(r.s2.ad))
    else $error("address latch not transparent");

  first_mode_a: assert property (seq_idle_start ##0 !mode_known_o |=>
    mode_known_o && mux_mode_o == $past(r.ale_seen))
    else $error("bus mode not chosen on first access");

  select_map_a: assert property (seq_idle_start |=>
    req_o.core_sel == !$past(r.s2.core_sel_n) && req_o.hdlc_sel == !$past(r.s2.hdlc_sel_n))
    else $error("chip select not mapped to register space");

  irq_pull_a: assert property (irq_pending_i && !r.s2.ext_rst |=> irq_n_oe_o && !irq_n_o)
    else $error("pending interrupt not pulled low");
endmodule
`default_nettype wire

//--- testbench/hbi_host_model.sv
// behavioural host bus master driving the port's pins
`timescale 1ns/1ns
`default_nettype none
module hbi_host_model
  import hbi_pkg::*;
(
  // clock
  input  wire logic          clk_i,
  // host pins and shared bus drive enable
  output hbi_pkg::hbi_pins_t pins_o,
  output logic               ad_en_o
);
  initial begin
    pins_o  = PINS_RST;
    ad_en_o = 1'b0;
  end

  // address phase, then select and strobes; all changes at the falling edge
  task automatic start(input logic sty, input logic mux, input logic rd, input logic hdlc,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_i);
    pins_o.strobe_dir = sty;
    pins_o.addr       = mux ? ~a : a;
    if (mux) begin
      pins_o.ale = 1'b1;
      pins_o.ad  = a;
      ad_en_o    = 1'b1;
      repeat (4) @(negedge clk_i);
      pins_o.ale = 1'b0;
      repeat (2) @(negedge clk_i);
    end
    pins_o.ad  = rd ? pins_o.ad : d;                  // released for a read, bench shows inverse
    ad_en_o    = ~rd;
    pins_o.core_sel_n = hdlc;
    pins_o.hdlc_sel_n = ~hdlc;
    pins_o.wr_n = rd;                                 // write strobe or direction
    pins_o.rd_n = sty ? 1'b0 : ~rd;                   // read strobe or data strobe
  endtask

  // strobe rises in the same step as select; bus let go
  task automatic finish();
    @(negedge clk_i);
    pins_o.rd_n = 1'b1;
    pins_o.wr_n = 1'b1;
    pins_o.core_sel_n = 1'b1;
    pins_o.hdlc_sel_n = 1'b1;
    ad_en_o     = 1'b0;                               // bench shows the inverse once let go
  endtask

  // external reset pin pulse, long enough for the synchroniser
  task automatic ext_reset();
    @(negedge clk_i);
    pins_o.ext_rst = 1'b1;
    repeat (4) @(negedge clk_i);
    pins_o.ext_rst = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_host_bus_interface_8bit.sv
// self-checking bench of the host bus port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_host_bus_interface_8bit;
  import hbi_pkg::*;
  logic clk_i = 1'b0, arst_n_i = 1'b0, irq_pending_i = 1'b0, ad_en, irq_n_o, irq_n_oe_o, oe, known, mux;
  logic [DATA_W-1:0] rd_data_i = 8'h96, ad_o, ad_i;
  hbi_pins_t pins;
  hbi_req_t  req, last;
  int n_errors = 0, cmp_count = 0, n_rd = 0, n_wr = 0, cyc = 0;

  always #20 clk_i = ~clk_i;
  // released bus shows the inverse of the host's last value, not a held copy
  assign ad_i = oe ? ad_o : (ad_en ? pins.ad : ~pins.ad);

  hbi_host_model u_host (.clk_i(clk_i), .pins_o(pins), .ad_en_o(ad_en));
  hbi_host_port u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .core_select_n_i(pins.core_sel_n),
    .hdlc_select_n_i(pins.hdlc_sel_n), .wr_n_i(pins.wr_n), .data_strobe_i(pins.rd_n), .ale_i(pins.ale),
    .external_reset_in_i(pins.ext_rst), .strobe_dir_mode_i(pins.strobe_dir), .addr_i(pins.addr),
    .shared_ad_i(ad_i), .shared_ad_o(ad_o), .shared_ad_oe_o(oe), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .req_o(req), .rd_data_i(rd_data_i), .irq_pending_i(irq_pending_i),
    .mode_known_o(known), .mux_mode_o(mux));

  // strobe counters, last request kept, hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (req.rd_stb === 1'b1) begin n_rd++; last = req; end
    if (req.wr_stb === 1'b1) begin n_wr++; last = req; end
    if (cyc == 3000) begin n_errors++; stop_test(); end
  end

  task automatic stop_test();
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one access held seven cycles, judged during and after the strobe
  task automatic xfer(input logic sty, input logic mx, input logic rd, input logic hd,
                      input logic [7:0] a, input logic [7:0] d);
    int r0, w0;
    r0 = n_rd; w0 = n_wr;
    u_host.start(sty, mx, rd, hd, a, d);
    repeat (6) @(negedge clk_i);
    `CHK("oe_during", rd, oe)
    if (rd) `CHK("rdata", rd_data_i, ad_o)
    u_host.finish();
    repeat (8) @(negedge clk_i);
    `CHK("oe_after", 1'b0, oe)
    `CHK("n_rd", r0 + int'(rd), n_rd)
    `CHK("n_wr", w0 + int'(!rd), n_wr)
    `CHK("addr", a, last.addr)
    `CHK("core_sel", !hd, last.core_sel)
    `CHK("hdlc_sel", hd, last.hdlc_sel)
    if (!rd) `CHK("wdata", d, last.wdata)
  endtask

  task automatic t_mux_first();
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h5A, 8'hC3);
    `CHK("known", 1'b1, known)
    `CHK("mux", 1'b1, mux)
    rd_data_i = 8'h69;
    xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h21, 8'h00);
    `CHK("mux_kept", 1'b1, mux)
  endtask

  task automatic t_ext_reset();
    u_host.ext_reset();
    repeat (4) @(negedge clk_i);
    `CHK("known_rst", 1'b0, known)
    `CHK("mux_rst", 1'b0, mux)
  endtask

  task automatic t_demux_strobe();
    xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h3C, 8'h00);
    `CHK("demux", 1'b0, mux)
    `CHK("known_d", 1'b1, known)
    xfer(1'b1, 1'b0, 1'b0, 1'b1, 8'hE7, 8'h18);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'hFF, 8'h00);
    `CHK("demux_kept", 1'b0, mux)
  endtask

  task automatic t_irq();
    irq_pending_i = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK("irq_oe", 1'b1, irq_n_oe_o)
    `CHK("irq_lvl", 1'b0, irq_n_o)
    irq_pending_i = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK("irq_off", 1'b0, irq_n_oe_o)
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_mux_first();
    t_ext_reset();
    t_demux_strobe();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
